/* File: src/stimulus_response_config.sv */
// Three stimulus response registers on AHB-Lite and the switch controls they drive.
// Assumes stimulus and emulation-reset pins are asynchronous and a single bus slave.
`timescale 1ns/10ps
// What this block does
// R1: Response registers keep contents across Sleep entry and exit.
// R2: Bits 7-4 hold magnitude; meaning depends on the selector.
// R3: Writes with reserved codes are rejected; old field value stays.
// R4: Bits 3-0 hold the response selector for the data lines.
// R5: Selector 0000 removes previous responses on both lines.
// R6: 0001 voltage on positive, 0010 on negative, 0011 on both.
// R7: 0100 resistor positive to ground, 0111 negative to ground.
// R8: 0110, 1001 and 1100 connect a bus-power divider.
// R9: 1010 connects a low resistor between the two lines.
// R10: 1101 connects resistors from both lines to ground.
// R11: Pull-down code keeps pull-downs on 000, removes on 111.
// R12: Positive-only response keeps negative pull-down only when idle on 000.
// R13: Negative-only response keeps positive pull-down only when idle on 000.
// R14: Voltage codes read magnitude as voltage level.
// R15: Resistor codes read magnitude as resistor value.
// R16: Divider codes read magnitude as minimum divider resistance.
// R17: Line-to-line code ignores the magnitude.
// R18: Stimulus 000 is power ready, 111 is power present.
// R19: Switch enables change only when a stimulus event fires or an emulation reset is seen.
module stimulus_response_config (
  input  wire logic        REF_CLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic [2:0]  STIM_FIRE_I,
  input  wire logic        EMU_RESET_I,
  input  wire logic        SLEEP_I,
  output logic             POS_VOLT_EN_O,
  output logic             NEG_VOLT_EN_O,
  output logic             POS_RES_EN_O,
  output logic             NEG_RES_EN_O,
  output logic             POS_DIV_EN_O,
  output logic             NEG_DIV_EN_O,
  output logic             LINE_SHORT_EN_O,
  output logic             POS_PULLDOWN_EN_O,
  output logic             NEG_PULLDOWN_EN_O,
  output logic      [3:0]  VOLT_MAG_O,
  output logic      [3:0]  RES_MAG_O,
  output logic      [3:0]  DIV_MAG_O
);

  localparam int unsigned NS = stim_resp_pkg::NUM_STIM;
  localparam int unsigned AW = stim_resp_pkg::ADDR_W;
  localparam int unsigned FW = stim_resp_pkg::FIELD_W;
  localparam int unsigned SW = stim_resp_pkg::STIM_W;

  typedef struct packed {
    logic [NS-1:0][7:0]    cfg;
    logic [NS-1:0][SW-1:0] stim_sel;
    logic [NS-1:0]         fire_s1;
    logic [NS-1:0]         fire_s2;
    logic [NS-1:0]         fire_d;
    logic [NS-1:0]         pending;
    logic                  emu_s1;
    logic                  emu_s2;
    logic                  sleep_s1;
    logic                  sleep_s2;
    logic                  wr_pend;
    logic [AW-1:0]         wr_addr;
    logic [31:0]           rdata;
    logic                  ready;
    logic                  resp;
    stim_resp_pkg::sw_s    sw;
  } state_s;

  state_s        q;
  state_s        next_q;
  logic          accept;
  logic [NS-1:0] edges;
  logic [NS-1:0] serve_vec;
  logic [NS-1:0] served;
  logic [1:0]    serve_idx;
  logic          serve_any;

  resp_decode_if dec ();

  resp_decode u_decode (
    .dec (dec.decode)
  );

  function automatic logic [FW-1:0] sel_of(input logic [7:0] r);
    return r[stim_resp_pkg::SEL_LSB +: FW];
  endfunction

  function automatic logic [FW-1:0] mag_of(input logic [7:0] r);
    return r[stim_resp_pkg::MAG_LSB +: FW];
  endfunction

  function automatic logic [1:0] idx_of(input logic [NS-1:0] onehot);
    logic [1:0] r;
    r = 2'h0;
    for (int k = 0; k < NS; k++) begin
      if (onehot[k]) begin
        r = 2'(k);
      end
    end
    return r;
  endfunction

  function automatic logic [AW-1:0] cfg_addr(input int k);
    return stim_resp_pkg::byte_addr(stim_resp_pkg::IDX_CFG[k]);
  endfunction

  // Reads see the state after any write landing this cycle, so no stale read-after-write
  function automatic logic [31:0] read_word(input state_s s, input logic [AW-1:0] a);
    logic [31:0] r;
    r = 32'h0;
    for (int k = 0; k < NS; k++) begin
      if (a == cfg_addr(k)) begin
        r[7:0] = s.cfg[k];
      end
    end
    if (a == stim_resp_pkg::byte_addr(stim_resp_pkg::IDX_STIM_SEL)) begin
      for (int k = 0; k < NS; k++) begin
        r[k*stim_resp_pkg::STIM_STRIDE +: SW] = s.stim_sel[k];
      end
    end
    if (a == stim_resp_pkg::byte_addr(stim_resp_pkg::IDX_SW_STATUS)) begin
      r[$bits(stim_resp_pkg::sw_s)-1:0] = s.sw;
      r[$bits(stim_resp_pkg::sw_s) +: NS] = s.pending;
      r[$bits(stim_resp_pkg::sw_s) + NS] = s.sleep_s2;
    end
    return r;
  endfunction

  assign accept = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign edges = q.fire_s2 & ~q.fire_d;
  assign serve_vec = q.pending | edges;
  // Lowest stimulus number wins when several are waiting
  assign served = serve_vec & (~serve_vec + 3'h1);
  assign serve_idx = idx_of(served);
  assign serve_any = |serve_vec && !q.emu_s2;

  assign dec.selector = sel_of(q.cfg[serve_idx]);
  assign dec.response_magnitude = mag_of(q.cfg[serve_idx]);
  assign dec.stimulus_select = q.stim_sel[serve_idx];
  assign dec.cur = q.sw;

  always_comb begin
    next_q = q;
    next_q.fire_s1 = STIM_FIRE_I;
    next_q.fire_s2 = q.fire_s1;
    next_q.fire_d = q.fire_s2;
    next_q.emu_s1 = EMU_RESET_I;
    next_q.emu_s2 = q.emu_s1;
    next_q.sleep_s1 = SLEEP_I;
    next_q.sleep_s2 = q.sleep_s1;
    next_q.ready = 1'b1;
    next_q.resp = 1'b0;
    // R1: no Sleep term on the registers
    if (q.wr_pend) begin
      for (int k = 0; k < NS; k++) begin
        if (q.wr_addr == cfg_addr(k)) begin
          // R3 R4: selector unless reserved
          if (!stim_resp_pkg::sel_reserved(sel_of(HWDATA_I[7:0]))) begin
            next_q.cfg[k][stim_resp_pkg::SEL_LSB +: FW] = sel_of(HWDATA_I[7:0]);
          end
          // R3 R2: magnitude unless reserved
          if (!stim_resp_pkg::mag_reserved(mag_of(HWDATA_I[7:0]), sel_of(HWDATA_I[7:0])))
          begin
            next_q.cfg[k][stim_resp_pkg::MAG_LSB +: FW] = mag_of(HWDATA_I[7:0]);
          end
        end
        // R3 R18: stimulus code unless reserved
        if (q.wr_addr == stim_resp_pkg::byte_addr(stim_resp_pkg::IDX_STIM_SEL) &&
            !stim_resp_pkg::stim_reserved(HWDATA_I[k*stim_resp_pkg::STIM_STRIDE +: SW])) begin
          next_q.stim_sel[k] = HWDATA_I[k*stim_resp_pkg::STIM_STRIDE +: SW];
        end
      end
    end
    if (q.emu_s2) begin
      // Emulation reset drops every response and restores both pull-downs
      next_q.sw = '0;
      next_q.sw.pos_pd = 1'b1;
      next_q.sw.neg_pd = 1'b1;
      next_q.pending = '0;
    end else begin
      // A new edge on a stimulus being served stays pending
      next_q.pending = (serve_vec & ~served) | (edges & q.pending);
      // R19: switches move only on an event
      if (serve_any) begin
        next_q.sw = dec.nxt;
      end
    end
    next_q.wr_pend = accept && HWRITE_I;
    next_q.wr_addr = HADDR_I[AW-1:0];
    next_q.rdata = 32'h0;
    if (accept && !HWRITE_I) begin
      next_q.rdata = read_word(next_q, HADDR_I[AW-1:0]);
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      q <= '0;
      q.ready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign HRDATA_O = q.rdata;
  assign HREADYOUT_O = q.ready;
  assign HRESP_O = q.resp;
  assign POS_VOLT_EN_O = q.sw.pos_volt;
  assign NEG_VOLT_EN_O = q.sw.neg_volt;
  assign POS_RES_EN_O = q.sw.pos_res;
  assign NEG_RES_EN_O = q.sw.neg_res;
  assign POS_DIV_EN_O = q.sw.pos_div;
  assign NEG_DIV_EN_O = q.sw.neg_div;
  assign LINE_SHORT_EN_O = q.sw.line_short;
  assign POS_PULLDOWN_EN_O = q.sw.pos_pd;
  assign NEG_PULLDOWN_EN_O = q.sw.neg_pd;
  assign VOLT_MAG_O = q.sw.volt_mag;
  assign RES_MAG_O = q.sw.res_mag;
  assign DIV_MAG_O = q.sw.div_mag;

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  sequence s_serve(logic [3:0] code);
    serve_any && dec.selector == code;
  endsequence

  sequence s_wr_cfg0;
    q.wr_pend && q.wr_addr == cfg_addr(0);
  endsequence

  sequence s_rd_cfg0;
    accept && !HWRITE_I && !q.wr_pend && HADDR_I[AW-1:0] == cfg_addr(0);
  endsequence

  sequence s_edge0;
    !q.fire_s2[0] && !q.emu_s2 ##1 q.fire_s2[0] && !q.emu_s2;
  endsequence

  AST_CFG_ONLY_BY_WRITE: assert property ( // R1
    !q.wr_pend |=> $stable(q.cfg))
    else $error("Response register changed without a bus write");

  AST_SEL_RSVD_REJECT: assert property ( // R3
    s_wr_cfg0 ##0 stim_resp_pkg::sel_reserved(HWDATA_I[3:0])
    |=> sel_of(q.cfg[0]) == $past(sel_of(q.cfg[0])))
    else $error("Reserved selector code was stored");

  AST_SEL_WRITE: assert property ( // R4
    s_wr_cfg0 ##0 !stim_resp_pkg::sel_reserved(HWDATA_I[3:0])
    |=> sel_of(q.cfg[0]) == $past(HWDATA_I[3:0]))
    else $error("Valid selector write not stored");

  AST_MAG_WRITE: assert property ( // R2
    s_wr_cfg0 ##0 !stim_resp_pkg::mag_reserved(HWDATA_I[7:4], HWDATA_I[3:0])
    |=> mag_of(q.cfg[0]) == $past(HWDATA_I[7:4]))
    else $error("Valid magnitude write not stored");

  AST_READ_BACK: assert property ( // R4
    s_rd_cfg0 |=> HRDATA_O == {24'h0, q.cfg[0]} && HREADYOUT_O && !HRESP_O)
    else $error("Read of first response register returned wrong data");

  AST_FIRE_TO_SWITCH: assert property ( // R19
    s_edge0 ##0 sel_of(q.cfg[0]) == stim_resp_pkg::SEL_SHORT
    |=> LINE_SHORT_EN_O)
    else $error("Stimulus edge did not apply its response");

  AST_REMOVE_ALL: assert property ( // R5
    s_serve(stim_resp_pkg::SEL_REMOVE) |=> !(POS_VOLT_EN_O || NEG_VOLT_EN_O ||
    POS_RES_EN_O || NEG_RES_EN_O || POS_DIV_EN_O || NEG_DIV_EN_O || LINE_SHORT_EN_O))
    else $error("Remove code left a response applied");

  AST_VOLT_POS: assert property ( // R14
    s_serve(stim_resp_pkg::SEL_VOLT_POS)
    |=> POS_VOLT_EN_O && VOLT_MAG_O == $past(dec.response_magnitude))
    else $error("Positive voltage response or level wrong");

  AST_NEG_PD_DROP: assert property ( // R12
    s_serve(stim_resp_pkg::SEL_VOLT_POS)
    ##0 dec.stimulus_select != stim_resp_pkg::STIM_VBUS_READY |=> !NEG_PULLDOWN_EN_O)
    else $error("Negative pull-down kept after a post-ready stimulus");

  AST_PD_KEEP: assert property ( // R11
    s_serve(stim_resp_pkg::SEL_PD_E) ##0 dec.stimulus_select == stim_resp_pkg::STIM_VBUS_READY
    |=> POS_PULLDOWN_EN_O && NEG_PULLDOWN_EN_O)
    else $error("Pull-downs not kept for power-ready stimulus");

  AST_SHORT_NO_MAG: assert property ( // R17
    s_serve(stim_resp_pkg::SEL_SHORT)
    |=> LINE_SHORT_EN_O && $stable(RES_MAG_O) && $stable(VOLT_MAG_O) && $stable(DIV_MAG_O))
    else $error("Line short changed a magnitude output");

  AST_DIV_MAG: assert property ( // R16
    s_serve(stim_resp_pkg::SEL_DIV_NEG)
    |=> NEG_DIV_EN_O && DIV_MAG_O == $past(dec.response_magnitude))
    else $error("Divider response or resistance wrong");

  AST_VOLT_NEG: assert property ( // R6
    s_serve(stim_resp_pkg::SEL_VOLT_NEG)
    |=> NEG_VOLT_EN_O && !NEG_PULLDOWN_EN_O)
    else $error("Negative voltage response not applied");

  AST_RES_POS: assert property ( // R7
    s_serve(stim_resp_pkg::SEL_RES_POS)
    |=> POS_RES_EN_O && RES_MAG_O == $past(dec.response_magnitude))
    else $error("Positive resistor response or value wrong");

  AST_DIV_POS: assert property ( // R8
    s_serve(stim_resp_pkg::SEL_DIV_POS)
    |=> POS_DIV_EN_O && !POS_PULLDOWN_EN_O)
    else $error("Positive divider response not applied");

  AST_SHORT_LINES: assert property ( // R9
    s_serve(stim_resp_pkg::SEL_SHORT)
    |=> LINE_SHORT_EN_O && !POS_PULLDOWN_EN_O && !NEG_PULLDOWN_EN_O)
    else $error("Line short applied with a pull-down still on");

  AST_RES_BOTH: assert property ( // R10
    s_serve(stim_resp_pkg::SEL_RES_BOTH)
    |=> POS_RES_EN_O && NEG_RES_EN_O && !POS_PULLDOWN_EN_O && !NEG_PULLDOWN_EN_O)
    else $error("Resistors on both lines not applied");

  AST_PD_DROP: assert property ( // R11
    s_serve(stim_resp_pkg::SEL_PD_F)
    ##0 dec.stimulus_select == stim_resp_pkg::STIM_VBUS_PRESENT
    |=> !POS_PULLDOWN_EN_O && !NEG_PULLDOWN_EN_O)
    else $error("Pull-downs kept for power-present stimulus");

  AST_POS_PD_HOLD: assert property ( // R13
    s_serve(stim_resp_pkg::SEL_VOLT_NEG)
    ##0 dec.stimulus_select == stim_resp_pkg::STIM_VBUS_READY
    ##0 POS_PULLDOWN_EN_O && !(POS_VOLT_EN_O || POS_RES_EN_O || POS_DIV_EN_O || LINE_SHORT_EN_O)
    |=> POS_PULLDOWN_EN_O)
    else $error("Positive pull-down dropped while that line was idle");

  AST_SWITCH_HOLD: assert property ( // R19
    !serve_any && !q.emu_s2 |=> $stable(q.sw))
    else $error("Switch state moved without a stimulus event");

endmodule // stimulus_response_config

/* File: src/stim_resp_pkg.sv */
// Constants, register map and switch-state layout for the stimulus response block.
// Assumes a 32-bit AHB-Lite register bus and an analog switch network driven by flops.
package stim_resp_pkg;
  localparam int unsigned NUM_STIM = 3;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned FIELD_W = 4;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned MAG_LSB = 4;
  localparam int unsigned STIM_W = 3;
  localparam int unsigned STIM_STRIDE = 4;
  localparam int unsigned SHORT_MAX_OHM = 200;
  // Register indices; byte address is four times the index
  localparam logic [NUM_STIM-1:0][7:0] IDX_CFG = {8'h3a, 8'h36, 8'h32};
  localparam logic [7:0] IDX_STIM_SEL = 8'h3c;
  localparam logic [7:0] IDX_SW_STATUS = 8'h3d;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [3:0] SEL_REMOVE = 4'h0;
  localparam logic [3:0] SEL_VOLT_POS = 4'h1;
  localparam logic [3:0] SEL_VOLT_NEG = 4'h2;
  localparam logic [3:0] SEL_VOLT_BOTH = 4'h3;
  localparam logic [3:0] SEL_RES_POS = 4'h4;
  localparam logic [3:0] SEL_RSVD_A = 4'h5;
  localparam logic [3:0] SEL_DIV_POS = 4'h6;
  localparam logic [3:0] SEL_RES_NEG = 4'h7;
  localparam logic [3:0] SEL_RSVD_B = 4'h8;
  localparam logic [3:0] SEL_DIV_NEG = 4'h9;
  localparam logic [3:0] SEL_SHORT = 4'ha;
  localparam logic [3:0] SEL_RSVD_C = 4'hb;
  localparam logic [3:0] SEL_DIV_BOTH = 4'hc;
  localparam logic [3:0] SEL_RES_BOTH = 4'hd;
  localparam logic [3:0] SEL_PD_E = 4'he;
  localparam logic [3:0] SEL_PD_F = 4'hf;
  localparam logic [3:0] MAG_RSVD = 4'hf;
  localparam logic [2:0] STIM_VBUS_READY = 3'h0;
  localparam logic [2:0] STIM_VBUS_PRESENT = 3'h7;
  localparam logic [2:0] STIM_RSVD_A = 3'h4;
  localparam logic [2:0] STIM_RSVD_B = 3'h5;

  typedef struct packed {
    logic       pos_volt;
    logic       neg_volt;
    logic       pos_res;
    logic       neg_res;
    logic       pos_div;
    logic       neg_div;
    logic       line_short;
    logic       pos_pd;
    logic       neg_pd;
    logic [3:0] volt_mag;
    logic [3:0] res_mag;
    logic [3:0] div_mag;
  } sw_s;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    return {idx, 2'h0};
  endfunction
  function automatic logic sel_reserved(input logic [3:0] s);
    return (s == SEL_RSVD_A) || (s == SEL_RSVD_B) || (s == SEL_RSVD_C);
  endfunction
  // Line-to-line short ignores magnitude, so every code is acceptable there
  function automatic logic mag_reserved(input logic [3:0] m, input logic [3:0] s);
    return (m == MAG_RSVD) && (s != SEL_SHORT);
  endfunction
  function automatic logic stim_reserved(input logic [2:0] c);
    return (c == STIM_RSVD_A) || (c == STIM_RSVD_B);
  endfunction
endpackage

/* File: src/resp_decode_if.sv */
// Carries one stored response and the present switch state to the decoder.
// Assumes the main module drives every request signal every cycle.
`timescale 1ns/10ps
interface resp_decode_if;
  logic                  [3:0] selector;
  logic                  [3:0] response_magnitude;
  logic                  [2:0] stimulus_select;
  stim_resp_pkg::sw_s          cur;
  stim_resp_pkg::sw_s          nxt;
  modport main (output selector, output response_magnitude, output stimulus_select,
                output cur, input nxt);
  modport decode (input selector, input response_magnitude, input stimulus_select,
                  input cur, output nxt);
endinterface

/* File: src/resp_decode.sv */
// Pure decode of a selector/magnitude pair into the next data-line switch state.
// Assumes the caller only registers the result when a stimulus fires.
`timescale 1ns/10ps
module resp_decode (
  resp_decode_if.decode dec
);
  // Opposite line keeps its reset pull-down only on a pre-switch stimulus with no response
  function automatic logic hold_pd(input logic pd, input logic keep, input logic idle);
    return pd & keep & idle;
  endfunction

  always_comb begin
    stim_resp_pkg::sw_s n;
    logic               keep;
    logic               pos_idle;
    logic               neg_idle;
    n = dec.cur;
    keep = (dec.stimulus_select == stim_resp_pkg::STIM_VBUS_READY);
    pos_idle = !(dec.cur.pos_volt | dec.cur.pos_res | dec.cur.pos_div | dec.cur.line_short);
    neg_idle = !(dec.cur.neg_volt | dec.cur.neg_res | dec.cur.neg_div | dec.cur.line_short);
    case (dec.selector)
      // R5: clear all responses
      stim_resp_pkg::SEL_REMOVE: begin
        {n.pos_volt, n.neg_volt, n.pos_res, n.neg_res} = 4'h0;
        {n.pos_div, n.neg_div, n.line_short} = 3'h0;
      end
      // R6 R12: voltage positive only
      stim_resp_pkg::SEL_VOLT_POS: begin
        n.pos_volt = 1'b1;
        n.pos_pd = 1'b0;
        n.neg_pd = hold_pd(dec.cur.neg_pd, keep, neg_idle);
      end
      // R6 R13: voltage negative only
      stim_resp_pkg::SEL_VOLT_NEG: begin
        n.neg_volt = 1'b1;
        n.neg_pd = 1'b0;
        n.pos_pd = hold_pd(dec.cur.pos_pd, keep, pos_idle);
      end
      // R6: voltage on both
      stim_resp_pkg::SEL_VOLT_BOTH: begin
        {n.pos_volt, n.neg_volt, n.pos_pd, n.neg_pd} = 4'hc;
      end
      // R7 R12: resistor positive
      stim_resp_pkg::SEL_RES_POS: begin
        n.pos_res = 1'b1;
        n.pos_pd = 1'b0;
        n.neg_pd = hold_pd(dec.cur.neg_pd, keep, neg_idle);
      end
      // R7 R13: resistor negative
      stim_resp_pkg::SEL_RES_NEG: begin
        n.neg_res = 1'b1;
        n.neg_pd = 1'b0;
        n.pos_pd = hold_pd(dec.cur.pos_pd, keep, pos_idle);
      end
      // R8 R12: divider on positive
      stim_resp_pkg::SEL_DIV_POS: begin
        n.pos_div = 1'b1;
        n.pos_pd = 1'b0;
        n.neg_pd = hold_pd(dec.cur.neg_pd, keep, neg_idle);
      end
      // R8 R13: divider on negative
      stim_resp_pkg::SEL_DIV_NEG: begin
        n.neg_div = 1'b1;
        n.neg_pd = 1'b0;
        n.pos_pd = hold_pd(dec.cur.pos_pd, keep, pos_idle);
      end
      // R8: divider on both
      stim_resp_pkg::SEL_DIV_BOTH: begin
        {n.pos_div, n.neg_div, n.pos_pd, n.neg_pd} = 4'hc;
      end
      // R9: line-to-line short
      stim_resp_pkg::SEL_SHORT: begin
        {n.line_short, n.pos_pd, n.neg_pd} = 3'h4;
      end
      // R10: resistors on both
      stim_resp_pkg::SEL_RES_BOTH: begin
        {n.pos_res, n.neg_res, n.pos_pd, n.neg_pd} = 4'hc;
      end
      // R11 R18: pull-down keep or drop
      stim_resp_pkg::SEL_PD_E, stim_resp_pkg::SEL_PD_F: begin
        if (keep) begin
          {n.pos_pd, n.neg_pd} = 2'h3;
        end else if (dec.stimulus_select == stim_resp_pkg::STIM_VBUS_PRESENT) begin
          {n.pos_pd, n.neg_pd} = 2'h0;
        end
      end
      default: begin
      end
    endcase
    // R14 R15 R16 R17: magnitude meaning per selector
    case (dec.selector)
      stim_resp_pkg::SEL_REMOVE, stim_resp_pkg::SEL_VOLT_POS,
      stim_resp_pkg::SEL_VOLT_NEG, stim_resp_pkg::SEL_VOLT_BOTH: begin
        n.volt_mag = dec.response_magnitude;
      end
      stim_resp_pkg::SEL_RES_POS, stim_resp_pkg::SEL_RES_NEG, stim_resp_pkg::SEL_RES_BOTH,
      stim_resp_pkg::SEL_PD_E, stim_resp_pkg::SEL_PD_F: begin
        n.res_mag = dec.response_magnitude;
      end
      stim_resp_pkg::SEL_DIV_POS, stim_resp_pkg::SEL_DIV_NEG, stim_resp_pkg::SEL_DIV_BOTH: begin
        n.div_mag = dec.response_magnitude;
      end
      default: begin
      end
    endcase
    dec.nxt = n;
  end
endmodule // resp_decode

/* File: verif/usb_port_model.sv */
// Portable-device side: raises the stimulus event pins on request.
// Assumes one-cycle requests from the bench, made just after a rising edge.
`timescale 1ns/10ps
module usb_port_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] req_i,
  output logic      [2:0] fire_o
);
  logic [2:0][1:0] cnt;
  // Pin held three cycles so the double sync cannot miss it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      fire_o <= '0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (req_i[k]) begin
          cnt[k] <= 2'h3;
        end else if (cnt[k] != 2'h0) begin
          cnt[k] <= cnt[k] - 2'h1;
        end
        fire_o[k] <= req_i[k] || (cnt[k] > 2'h1);
      end
    end
  end
endmodule // usb_port_model

/* File: verif/tb_stimulus_response_config.sv */
// Self-checking bench: AHB-Lite register access plus stimulus events.
// Assumes a single bus slave, so hreadyout is fed back as hready.
`timescale 1ns/10ps
module tb_stimulus_response_config;
  typedef struct packed {
    logic       emu;
    logic [2:0] code;
    logic [3:0] sel;
    logic [8:0] exp;
  } case_s;
  localparam logic [7:0] c1 = stim_resp_pkg::IDX_CFG[0];
  localparam logic [7:0] csel = stim_resp_pkg::IDX_STIM_SEL;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        emu = 1'b0;
  logic        sleep = 1'b0;
  logic [2:0]  req = 3'h0;
  wire  [2:0]  fire;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  wire  [8:0]  en;
  wire  [3:0]  vmag;
  wire  [3:0]  rmag;
  wire  [3:0]  dmag;
  wire  [20:0] sw = {en, vmag, rmag, dmag};
  int          fails = 0;
  int          tests_run = 0;
  case_s       tbl [16] = '{
    '{1'b1, 3'h0, 4'h1, 9'h101}, '{1'b0, 3'h0, 4'h2, 9'h180}, '{1'b0, 3'h0, 4'h0, 9'h000},
    '{1'b1, 3'h0, 4'h2, 9'h082}, '{1'b1, 3'h7, 4'h1, 9'h100}, '{1'b1, 3'h0, 4'h3, 9'h180},
    '{1'b1, 3'h0, 4'h4, 9'h041}, '{1'b1, 3'h0, 4'h7, 9'h022}, '{1'b1, 3'h0, 4'h6, 9'h011},
    '{1'b1, 3'h0, 4'h9, 9'h00a}, '{1'b1, 3'h0, 4'hc, 9'h018}, '{1'b1, 3'h0, 4'ha, 9'h004},
    '{1'b1, 3'h0, 4'hd, 9'h060}, '{1'b1, 3'h0, 4'he, 9'h003}, '{1'b1, 3'h7, 4'hf, 9'h000},
    '{1'b1, 3'h3, 4'he, 9'h003}};

  always #20 clk = ~clk;

  stimulus_response_config dut (
    .REF_CLK_I(clk), .ARST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .STIM_FIRE_I(fire), .EMU_RESET_I(emu), .SLEEP_I(sleep),
    .POS_VOLT_EN_O(en[8]), .NEG_VOLT_EN_O(en[7]), .POS_RES_EN_O(en[6]),
    .NEG_RES_EN_O(en[5]), .POS_DIV_EN_O(en[4]), .NEG_DIV_EN_O(en[3]),
    .LINE_SHORT_EN_O(en[2]), .POS_PULLDOWN_EN_O(en[1]), .NEG_PULLDOWN_EN_O(en[0]),
    .VOLT_MAG_O(vmag), .RES_MAG_O(rmag), .DIV_MAG_O(dmag));

  usb_port_model port (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .fire_o(fire));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        give_verdict();
      end
      @(posedge clk);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    check(what, x, e);
  endtask

  task automatic fire_wait(input logic [2:0] m);
    req <= m;
    @(posedge clk);
    req <= 3'h0;
    repeat (8) @(posedge clk);
  endtask

  task automatic emu_pulse();
    emu <= 1'b1;
    repeat (4) @(posedge clk);
    emu <= 1'b0;
    repeat (4) @(posedge clk);
    check("emu reset state", en, 9'h003);
  endtask

  task automatic s_regs();
    logic [3:0] rsv [3] = '{4'h5, 4'h8, 4'hb};
    rd_chk("cfg3 reset", stim_resp_pkg::IDX_CFG[2], 32'h0);
    wr(c1, 32'hffff_ff31);
    rd_chk("cfg1 fields", c1, 32'h31);
    foreach (rsv[i]) begin
      wr(c1, {28'h2, rsv[i]});
      rd_chk("reserved selector", c1, 32'h21);
    end
    wr(c1, 32'hf1);
    rd_chk("reserved magnitude", c1, 32'h21);
    wr(c1, 32'hfa);
    rd_chk("short magnitude", c1, 32'hfa);
    wr(csel, 32'h470);
    rd_chk("stim codes", csel, 32'h070);
    wr(csel, 32'h774);
    rd_chk("stim codes", csel, 32'h770);
    wr(8'h10, 32'h5a);
    rd_chk("unmapped", 8'h10, 32'h0);
    // Sleep must not disturb stored settings
    sleep <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk("cfg1 in sleep", c1, 32'hfa);
    rd_chk("status in sleep", stim_resp_pkg::IDX_SW_STATUS, 32'h0100_0000);
    sleep <= 1'b0;
    rd_chk("cfg1 after sleep", c1, 32'hfa);
  endtask

  task automatic s_decode();
    logic [3:0]  m;
    logic [20:0] pre;
    foreach (tbl[i]) begin
      m = 4'(i % 15);
      if (tbl[i].emu) begin
        emu_pulse();
      end
      pre = sw;
      wr(csel, {29'h0, tbl[i].code});
      wr(c1, {24'h0, m, tbl[i].sel});
      check("held until event", sw, pre);
      fire_wait(3'h1);
      check("switches", en, tbl[i].exp);
      if (tbl[i].sel inside {4'h1, 4'h2, 4'h3}) begin
        check("volt mag", vmag, m);
      end
      if (tbl[i].sel inside {4'h4, 4'h7, 4'hd, 4'he, 4'hf} && tbl[i].code != 3'h3) begin
        check("res mag", rmag, m);
      end
      if (tbl[i].sel inside {4'h6, 4'h9, 4'hc}) begin
        check("div mag", dmag, m);
      end
    end
  endtask

  // All three events at once: served lowest first, each with its own register
  task automatic s_multi();
    emu_pulse();
    wr(csel, 32'h0);
    wr(c1, 32'h14);
    wr(stim_resp_pkg::IDX_CFG[1], 32'h27);
    wr(stim_resp_pkg::IDX_CFG[2], 32'h3d);
    fire_wait(3'h7);
    check("multi switches", en, 9'h060);
    check("multi res mag", rmag, 4'h3);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    s_regs();
    s_decode();
    s_multi();
    check("response okay", hresp, 1'b0);
    give_verdict();
  end
endmodule // tb_stimulus_response_config
